//--- sodrc_top.sv
// Sample FIFO and serial output and route configuration logic
`timescale 1ns/1ns
`default_nettype none

module sodrc_fifo
  import sodrc_pkg::*;
#(
  parameter int WIDTH = 2 * SAMPLE_W,
  parameter int DEPTH = FIFO_DEPTH_DEF
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
    logic full;
  } sodrc_fifo_state_t;

  sodrc_fifo_state_t s_q;
  sodrc_fifo_state_t s_d;

  always_comb
  begin
    logic push;
    logic pop;
    push = in_valid && !s_q.full;
    pop = out_ready && (s_q.cnt != '0);
    s_d = s_q;
    if (push)
    begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr = (s_q.wr == LAST) ? '0 : AW'(s_q.wr + 1'b1);
    end
    if (pop)
      s_d.rd = (s_q.rd == LAST) ? '0 : AW'(s_q.rd + 1'b1);
    if (push && !pop)
      s_d.cnt = (AW+1)'(s_q.cnt + 1'b1);
    else if (pop && !push)
      s_d.cnt = (AW+1)'(s_q.cnt - 1'b1);
    s_d.full = (s_d.cnt == FULL_CNT);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign in_ready = !s_q.full;
  assign out_valid = (s_q.cnt != '0);
  assign out_data = s_q.mem[s_q.rd];
endmodule

module sodrc_top
  import sodrc_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
  parameter int BIT_DIV = BIT_DIV_DEF
)
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Register port
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // Operating mode
  input wire sodrc_mode_t MODE,
  input wire sodrc_lanes_t LANES,
  input wire logic ROUTE_APPLY,
  // Converter samples
  input wire logic [SAMPLE_W-1:0] SAMPLE_A,
  input wire logic [SAMPLE_W-1:0] SAMPLE_B,
  input wire logic SAMPLE_VALID,
  output logic SAMPLE_READY,
  // Serial link
  output logic LANE_A,
  output logic LANE_B,
  output logic FRAME_CLOCK,
  output logic SERIAL_BIT_STROBE,
  // Frame clock and drive settings
  output logic FRAME_CLOCK_SOURCE_SELECT,
  output logic FRAME_CLOCK_DIVIDE,
  output logic FRAME_CLOCK_STRETCH,
  output logic [11:0] DRIVE_CURRENT_UA,
  output logic signed [2:0] DATA_SKEW_STEPS,
  output logic signed [2:0] BIT_CLOCK_SKEW_STEPS,
  output logic [4:0] OUT_RES,
  // Feature path status
  output logic FILTER_ENABLE,
  output logic FEATURE_PATH
);
  localparam int DW = $clog2(BIT_DIV + 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(BIT_DIV - 1);

  typedef struct packed {
    logic [7:0] drive;
    logic [7:0] remap;
    logic [7:0] skew;
    logic [7:0] route;
    logic [19:0] pat;
    logic [7:0] rdata;
    logic [4:0] res;
    logic [19:0] pat_eff;
    logic src;
    logic div;
    logic stretch;
    logic [11:0] current;
    logic signed [2:0] dskew;
    logic signed [2:0] cskew;
    logic [1:0] route_eff;
    logic [DW-1:0] div_cnt;
    logic bit_en;
    logic [4:0] bit_idx;
    logic [19:0] sh_a;
    logic [19:0] sh_b;
    logic [19:0] sh_p;
    logic lane_a;
    logic lane_b;
    logic frame;
    logic strobe;
  } sodrc_top_state_t;

  sodrc_top_state_t s_q;
  sodrc_top_state_t s_d;
  logic [2*SAMPLE_W-1:0] push_data;
  logic [2*SAMPLE_W-1:0] pop_data;
  logic pop_valid;
  logic pop_ready;
  logic fifo_ready;

  // Skew code to signed 50 ps steps
  function automatic logic signed [2:0] skew_steps(input logic [1:0] code);
    case (code)
      2'h1: skew_steps = -3'sd1;
      2'h2: skew_steps = 3'sd1;
      2'h3: skew_steps = 3'sd2;
      default: skew_steps = 3'sd0;
    endcase
  endfunction

  // Pattern high for the first half of a frame
  function automatic logic [19:0] auto_pat(input logic [4:0] res);
    auto_pat = ~(20'hfffff >> res[4:1]);
  endfunction

  // Sample left-justified into a frame word
  function automatic logic [19:0] frame_word(input logic [SAMPLE_W-1:0] v);
    frame_word = {v, (FRAME_W - SAMPLE_W)'(0)};
  endfunction

  // Routing in front of the downconverters
  always_comb
  begin
    logic [SAMPLE_W:0] sum;
    logic [SAMPLE_W-1:0] avg;
    logic [SAMPLE_W-1:0] a;
    logic [SAMPLE_W-1:0] b;
    sum = {SAMPLE_A[SAMPLE_W-1], SAMPLE_A} + {SAMPLE_B[SAMPLE_W-1], SAMPLE_B};
    avg = sum[SAMPLE_W:1];
    a = SAMPLE_A;
    b = SAMPLE_B;
    if (s_q.route[FEAT_BIT])
    begin
      case (s_q.route_eff)
        ROUTE_A_BOTH: b = SAMPLE_A;
        ROUTE_B_BOTH: a = SAMPLE_B;
        ROUTE_AVG:
        begin
          if (s_q.route[AVG_BIT] && s_q.route[DECIM_BIT])
          begin
            a = avg;
            b = avg;
          end
          else
            b = SAMPLE_A;
        end
        default:
        begin
          a = SAMPLE_A;
          b = SAMPLE_B;
        end
      endcase
    end
    push_data = {a, b};
  end

  sodrc_fifo #(
    .WIDTH(2 * SAMPLE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(REF_CLK),
    .rst(RST),
    .in_valid(SAMPLE_VALID),
    .in_data(push_data),
    .in_ready(fifo_ready),
    .out_valid(pop_valid),
    .out_data(pop_data),
    .out_ready(pop_ready)
  );

  assign pop_ready = s_q.bit_en && (s_q.bit_idx == '0);

  always_comb
  begin
    logic [19:0] na;
    logic [19:0] nb;
    logic [19:0] np;
    na = s_q.sh_a;
    nb = s_q.sh_b;
    np = s_q.sh_p;
    s_d = s_q;
    // Register writes
    if (REG_WR)
    begin
      case (REG_ADDR)
        ADDR_DRIVE: s_d.drive = REG_WDATA & MASK_DRIVE;
        ADDR_REMAP: s_d.remap = REG_WDATA & MASK_REMAP;
        ADDR_SKEW: s_d.skew = REG_WDATA & MASK_SKEW;
        ADDR_PAT_LO: s_d.pat[7:0] = REG_WDATA;
        ADDR_PAT_MID: s_d.pat[15:8] = REG_WDATA;
        ADDR_PAT_HI: s_d.pat[19:16] = REG_WDATA[3:0] & MASK_PAT_HI[3:0];
        ADDR_ROUTE: s_d.route = REG_WDATA & MASK_ROUTE;
        default: s_d.drive = s_q.drive;
      endcase
    end
    // Register reads, unmapped reads give zero
    if (REG_RD)
    begin
      case (REG_ADDR)
        ADDR_DRIVE: s_d.rdata = s_q.drive;
        ADDR_REMAP: s_d.rdata = s_q.remap;
        ADDR_SKEW: s_d.rdata = s_q.skew;
        ADDR_PAT_LO: s_d.rdata = s_q.pat[7:0];
        ADDR_PAT_MID: s_d.rdata = s_q.pat[15:8];
        ADDR_PAT_HI: s_d.rdata = {4'h0, s_q.pat[19:16]};
        ADDR_ROUTE: s_d.rdata = s_q.route;
        default: s_d.rdata = 8'h00;
      endcase
    end
    // Output resolution
    if (s_q.remap[TWENTY_BIT])
      s_d.res = RES_20;
    else if (MODE == MODE_REAL)
      s_d.res = RES_18;
    else if (MODE == MODE_COMPLEX)
      s_d.res = RES_16;
    else if (s_q.remap[REMAP_EN_BIT])
    begin
      case (s_q.remap[RES_LSB+:3])
        RES_CODE_18: s_d.res = RES_18;
        RES_CODE_16: s_d.res = RES_16;
        default: s_d.res = RES_14;
      endcase
    end
    else
      s_d.res = RES_14;
    // Frame-clock pattern in use
    if (MODE == MODE_BYPASS)
      s_d.pat_eff = auto_pat(s_d.res);
    else
      s_d.pat_eff = s_q.pat;
    // Frame-clock source, divide and stretch
    s_d.src = (MODE == MODE_COMPLEX) && (LANES != LANES_HALF);
    s_d.div = (MODE != MODE_COMPLEX) && (LANES == LANES_TWO);
    s_d.stretch = (MODE == MODE_COMPLEX) && (LANES == LANES_HALF);
    s_d.current = s_q.drive[HALF_SWING_BIT] ? DRIVE_HALF_UA
                                             : DRIVE_NOMINAL_UA;
    s_d.dskew = skew_steps(s_q.skew[DATA_SKEW_LSB+:2]);
    s_d.cskew = skew_steps(s_q.skew[BCLK_SKEW_LSB+:2]);
    s_d.route_eff = ROUTE_APPLY ? s_q.route[ROUTE_LSB+:2]
                                : ROUTE_STRAIGHT;
    // Serial bit period enable
    s_d.div_cnt = (s_q.div_cnt >= DIV_LAST) ? '0 : DW'(s_q.div_cnt + 1'b1);
    s_d.bit_en = (s_q.div_cnt >= DIV_LAST);
    s_d.strobe = s_q.bit_en;
    // Serializer, MSB first, frame clock in step with the lanes
    if (s_q.bit_en)
    begin
      if (s_q.bit_idx == '0)
      begin
        na = pop_valid ? frame_word(pop_data[2*SAMPLE_W-1:SAMPLE_W]) : '0;
        nb = pop_valid ? frame_word(pop_data[SAMPLE_W-1:0]) : '0;
        np = s_q.pat_eff;
      end
      s_d.lane_a = na[19];
      s_d.lane_b = nb[19];
      s_d.frame = np[19];
      s_d.sh_a = {na[18:0], 1'b0};
      s_d.sh_b = {nb[18:0], 1'b0};
      s_d.sh_p = {np[18:0], 1'b0};
      if (s_q.bit_idx >= 5'(s_q.res - 5'h01))
        s_d.bit_idx = '0;
      else
        s_d.bit_idx = 5'(s_q.bit_idx + 5'h01);
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      s_q <= '0;
      s_q.drive <= RST_BYTE;
      s_q.remap <= RST_BYTE;
      s_q.skew <= RST_BYTE;
      s_q.route <= RST_BYTE;
      s_q.pat <= RST_PAT;
      s_q.pat_eff <= RST_PAT;
      s_q.res <= RES_14;
      s_q.current <= DRIVE_NOMINAL_UA;
    end
    else
      s_q <= s_d;
  end

  assign REG_RDATA = s_q.rdata;
  assign SAMPLE_READY = fifo_ready;
  assign LANE_A = s_q.lane_a;
  assign LANE_B = s_q.lane_b;
  assign FRAME_CLOCK = s_q.frame;
  assign SERIAL_BIT_STROBE = s_q.strobe;
  assign FRAME_CLOCK_SOURCE_SELECT = s_q.src;
  assign FRAME_CLOCK_DIVIDE = s_q.div;
  assign FRAME_CLOCK_STRETCH = s_q.stretch;
  assign DRIVE_CURRENT_UA = s_q.current;
  assign DATA_SKEW_STEPS = s_q.dskew;
  assign BIT_CLOCK_SKEW_STEPS = s_q.cskew;
  assign OUT_RES = s_q.res;
  assign FILTER_ENABLE = s_q.route[DECIM_BIT];
  assign FEATURE_PATH = s_q.route[FEAT_BIT];

  property p_src;
    @(posedge REF_CLK) disable iff (RST)
    (MODE == MODE_COMPLEX && LANES != LANES_HALF)
      |=> FRAME_CLOCK_SOURCE_SELECT;
  endproperty
  a_src: assert property (p_src)
    else $error("frame clock source not downconverter");

  property p_stretch;
    @(posedge REF_CLK) disable iff (RST)
    FRAME_CLOCK_STRETCH |-> !FRAME_CLOCK_SOURCE_SELECT && !FRAME_CLOCK_DIVIDE;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("stretch with source or divide set");

  property p_half;
    @(posedge REF_CLK) disable iff (RST)
    s_q.drive[HALF_SWING_BIT] |=> DRIVE_CURRENT_UA == DRIVE_HALF_UA;
  endproperty
  a_half: assert property (p_half)
    else $error("half swing current wrong");

  property p_twenty;
    @(posedge REF_CLK) disable iff (RST)
    s_q.remap[TWENTY_BIT] |=> OUT_RES == RES_20;
  endproperty
  a_twenty: assert property (p_twenty)
    else $error("twenty bit output not selected");

  property p_cplx_res;
    @(posedge REF_CLK) disable iff (RST)
    (MODE == MODE_COMPLEX && !s_q.remap[TWENTY_BIT]) |=> OUT_RES == RES_16;
  endproperty
  a_cplx_res: assert property (p_cplx_res)
    else $error("remap acted outside bypass");

  property p_code16;
    @(posedge REF_CLK) disable iff (RST)
    (MODE == MODE_BYPASS && s_q.remap[REMAP_EN_BIT] && !s_q.remap[TWENTY_BIT]
     && s_q.remap[RES_LSB+:3] == RES_CODE_16) |=> OUT_RES == RES_16;
  endproperty
  a_code16: assert property (p_code16)
    else $error("remap code 001 not 16 bit");

  property p_dskew;
    @(posedge REF_CLK) disable iff (RST)
    s_q.skew[DATA_SKEW_LSB+:2] == 2'h3 |=> DATA_SKEW_STEPS == 3'sd2;
  endproperty
  a_dskew: assert property (p_dskew)
    else $error("data skew not two steps late");

  property p_cskew;
    @(posedge REF_CLK) disable iff (RST)
    s_q.skew[BCLK_SKEW_LSB+:2] == 2'h1 |=> BIT_CLOCK_SKEW_STEPS == -3'sd1;
  endproperty
  a_cskew: assert property (p_cskew)
    else $error("bit clock skew not one step early");

  property p_pat;
    @(posedge REF_CLK) disable iff (RST)
    MODE != MODE_BYPASS |=> s_q.pat_eff == $past(s_q.pat);
  endproperty
  a_pat: assert property (p_pat)
    else $error("programmed pattern not in use");

  property p_frame;
    @(posedge REF_CLK) disable iff (RST)
    (s_q.bit_en && s_q.bit_idx == '0)
      |=> FRAME_CLOCK == $past(s_q.pat_eff[19]);
  endproperty
  a_frame: assert property (p_frame)
    else $error("frame clock does not start with pattern msb");

  property p_route;
    @(posedge REF_CLK) disable iff (RST)
    !ROUTE_APPLY |=> s_q.route_eff == ROUTE_STRAIGHT;
  endproperty
  a_route: assert property (p_route)
    else $error("route applied without enable");
endmodule

`default_nettype wire

//--- sodrc_pkg.sv
// Constants and types for the serial output and route configuration block
// Function
// - Frame-clock source, divide and stretch follow mode and lane count.
// - Half-swing bit halves the output lane drive current.
// - Remap enable changes output resolution only in decimation bypass.
// - Twenty-bit enable gives 20-bit output samples.
// - Remap code 000 gives 18, 001 gives 16, 010 gives 14 bits.
// - Data skew codes: none, advance 50 ps, delay 50 ps, delay 100 ps.
// - Bit-clock skew codes: none, advance 50 ps, delay 50 ps, delay 100 ps.
// - 20-bit frame-clock pattern, reset 0xffc00, shapes the frame clock.
// - In bypass the pattern follows the output resolution automatically.
// - Averaging outputs (A+B)/2 given route 11, average bit 5, filter on, feature path.
// - Route 00 straight, 01 A to both, 10 B to both, 11 average.
// - Feature path 0 bypasses the feature block; 1 passes through it.
// - One enable switches the decimation filter on or off for both channels.
// - Route field acts only while route-apply enable is set.
// - Source 0 is converter frame clock, 1 downconverter; real as bypass.
package sodrc_pkg;
  localparam logic [7:0] ADDR_DRIVE = 8'h1a;
  localparam logic [7:0] ADDR_REMAP = 8'h1b;
  localparam logic [7:0] ADDR_SKEW = 8'h1e;
  localparam logic [7:0] ADDR_PAT_LO = 8'h20;
  localparam logic [7:0] ADDR_PAT_MID = 8'h21;
  localparam logic [7:0] ADDR_PAT_HI = 8'h22;
  localparam logic [7:0] ADDR_ROUTE = 8'h24;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [19:0] RST_PAT = 20'hffc00;
  localparam logic [7:0] MASK_DRIVE = 8'h40;
  localparam logic [7:0] MASK_REMAP = 8'hf8;
  localparam logic [7:0] MASK_SKEW = 8'h0f;
  localparam logic [7:0] MASK_PAT_HI = 8'h0f;
  localparam logic [7:0] MASK_ROUTE = 8'h3e;
  localparam int HALF_SWING_BIT = 6;
  localparam int REMAP_EN_BIT = 7;
  localparam int TWENTY_BIT = 6;
  localparam int RES_LSB = 3;
  localparam int DATA_SKEW_LSB = 2;
  localparam int BCLK_SKEW_LSB = 0;
  localparam int AVG_BIT = 5;
  localparam int ROUTE_LSB = 3;
  localparam int FEAT_BIT = 2;
  localparam int DECIM_BIT = 1;
  localparam logic [1:0] ROUTE_STRAIGHT = 2'h0;
  localparam logic [1:0] ROUTE_A_BOTH = 2'h1;
  localparam logic [1:0] ROUTE_B_BOTH = 2'h2;
  localparam logic [1:0] ROUTE_AVG = 2'h3;
  localparam logic [2:0] RES_CODE_18 = 3'h0;
  localparam logic [2:0] RES_CODE_16 = 3'h1;
  localparam logic [2:0] RES_CODE_14 = 3'h2;
  localparam logic [4:0] RES_14 = 5'h0e;
  localparam logic [4:0] RES_16 = 5'h10;
  localparam logic [4:0] RES_18 = 5'h12;
  localparam logic [4:0] RES_20 = 5'h14;
  localparam logic [11:0] DRIVE_NOMINAL_UA = 12'hdac;
  localparam logic [11:0] DRIVE_HALF_UA = 12'h6d6;
  localparam int SKEW_STEP_PS = 50;
  localparam int SAMPLE_W = 14;
  localparam int FRAME_W = 20;
  localparam int FIFO_DEPTH_DEF = 32;
  localparam int BIT_DIV_DEF = 1;
  typedef enum logic [1:0] {MODE_BYPASS, MODE_REAL, MODE_COMPLEX} sodrc_mode_t;
  typedef enum logic [1:0] {LANES_TWO, LANES_ONE, LANES_HALF} sodrc_lanes_t;
endpackage

//--- sodrc_rx_model.sv
// Receiver model that deserializes the lanes and the frame clock
`timescale 1ns/1ns
`default_nettype none

module sodrc_rx_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial link
  input wire logic lane_a,
  input wire logic lane_b,
  input wire logic frame_clock,
  input wire logic strobe,
  input wire logic [4:0] res,
  // Captured frame
  output logic [19:0] rx_a,
  output logic [19:0] rx_b,
  output logic [19:0] rx_fc,
  output logic rx_new,
  output logic [7:0] rx_nz
);
  logic [19:0] sa, sb, sf, na, nb, nf;
  logic [4:0] cnt, cnt_n;
  logic prev, start;

  // Frame starts where the frame clock rises; bits arrive MSB first
  always_comb
  begin
    start = frame_clock & ~prev;
    na = {start ? 19'h0 : sa[18:0], lane_a};
    nb = {start ? 19'h0 : sb[18:0], lane_b};
    nf = {start ? 19'h0 : sf[18:0], frame_clock};
    cnt_n = start ? 5'h01 : cnt + 5'h01;
  end

  always_ff @(posedge clk)
  begin
    rx_new <= 1'b0;
    if (rst)
    begin
      prev <= 1'b0;
      cnt <= 5'h00;
      rx_nz <= 8'h00;
    end
    else if (strobe)
    begin
      prev <= frame_clock;
      cnt <= cnt_n;
      sa <= na;
      sb <= nb;
      sf <= nf;
      if (cnt_n == res)
      begin
        rx_a <= na;
        rx_b <= nb;
        rx_fc <= nf;
        rx_new <= 1'b1;
        if ((na | nb) != 20'h0)
          rx_nz <= rx_nz + 8'h01;
      end
    end
  end
endmodule

`default_nettype wire

//--- sodrc_top_bench.sv
// Self-checking bench for the serial output and route configuration block
`timescale 1ns/1ns
`default_nettype none

module sodrc_top_bench
  import sodrc_pkg::*;
;
  localparam int DEPTH = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  sodrc_mode_t mode = MODE_BYPASS;
  sodrc_lanes_t lanes = LANES_ONE;
  logic apply = 1'b0;
  logic [13:0] sa = 14'h0000;
  logic [13:0] sb = 14'h0000;
  logic sv = 1'b0;
  logic sr, la, lb, fc, stb, src, div, str, filt, feat;
  logic [11:0] drv;
  logic signed [2:0] dsk, bsk;
  logic [4:0] res;
  logic [19:0] rx_a, rx_b, rx_fc;
  logic rx_new;
  logic [7:0] rx_nz;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;

  always #2 clk = ~clk;

  sodrc_top #(.FIFO_DEPTH(DEPTH)) i_dut (.REF_CLK(clk), .RST(rst),
    .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_RDATA(rdata), .MODE(mode), .LANES(lanes), .ROUTE_APPLY(apply),
    .SAMPLE_A(sa), .SAMPLE_B(sb), .SAMPLE_VALID(sv), .SAMPLE_READY(sr),
    .LANE_A(la), .LANE_B(lb), .FRAME_CLOCK(fc), .SERIAL_BIT_STROBE(stb),
    .FRAME_CLOCK_SOURCE_SELECT(src), .FRAME_CLOCK_DIVIDE(div),
    .FRAME_CLOCK_STRETCH(str), .DRIVE_CURRENT_UA(drv),
    .DATA_SKEW_STEPS(dsk), .BIT_CLOCK_SKEW_STEPS(bsk), .OUT_RES(res),
    .FILTER_ENABLE(filt), .FEATURE_PATH(feat));

  sodrc_rx_model i_rx (.clk(clk), .rst(rst), .lane_a(la), .lane_b(lb),
    .frame_clock(fc), .strobe(stb), .res(res), .rx_a(rx_a), .rx_b(rx_b),
    .rx_fc(rx_fc), .rx_new(rx_new), .rx_nz(rx_nz));

  task automatic check(input string name, input logic [19:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wreg(input logic [7:0] a, d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    check($sformatf("reg %h", a), {12'h0, rdata}, {12'h0, e});
  endtask

  task automatic push(input logic [13:0] a, b);
    @(posedge clk);
    sv <= 1'b1;
    sa <= a;
    sb <= b;
    do @(posedge clk); while (sr !== 1'b1);
    sv <= 1'b0;
  endtask

  task automatic see(input logic [19:0] ea, eb);
    int n = 0;
    while (!(rx_new === 1'b1 && (rx_a | rx_b) != 20'h0) && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    check("lane a", rx_a, ea);
    check("lane b", rx_b, eb);
  endtask

  task automatic frames(input int k);
    int n = 0;
    int c = 0;
    while (c < k && n < 1000)
    begin
      @(posedge clk);
      n++;
      if (rx_new === 1'b1)
        c++;
    end
  endtask

  task automatic t_reset;
    rchk(ADDR_DRIVE, 8'h00);
    rchk(ADDR_REMAP, 8'h00);
    rchk(ADDR_SKEW, 8'h00);
    rchk(ADDR_PAT_LO, 8'h00);
    rchk(ADDR_PAT_MID, 8'hfc);
    rchk(ADDR_PAT_HI, 8'h0f);
    rchk(ADDR_ROUTE, 8'h00);
    rchk(8'h1c, 8'h00);
    check("res", 20'(res), 20'(RES_14));
    check("drive", 20'(drv), 20'(DRIVE_NOMINAL_UA));
    $display("t_reset done");
  endtask

  task automatic t_drive;
    wreg(ADDR_DRIVE, 8'hff);
    tick(3);
    rchk(ADDR_DRIVE, 8'h40);
    check("half", 20'(drv), 20'(DRIVE_HALF_UA));
    wreg(ADDR_DRIVE, 8'h00);
    tick(3);
    check("full", 20'(drv), 20'(DRIVE_NOMINAL_UA));
    $display("t_drive done");
  endtask

  task automatic t_skew;
    logic [2:0] st [4] = '{3'h0, 3'h7, 3'h1, 3'h2};
    for (int i = 0; i < 4; i++)
    begin
      wreg(ADDR_SKEW, 8'(i * 4 + (3 - i)) | 8'hf0);
      tick(3);
      check("dskew", {17'h0, dsk}, {17'h0, st[i]});
      check("bskew", {17'h0, bsk}, {17'h0, st[3 - i]});
    end
    rchk(ADDR_SKEW, 8'h0c);
    $display("t_skew done");
  endtask

  task automatic t_res;
    sodrc_mode_t m [10] = '{MODE_BYPASS, MODE_BYPASS, MODE_BYPASS,
      MODE_BYPASS, MODE_BYPASS, MODE_BYPASS, MODE_REAL, MODE_REAL,
      MODE_COMPLEX, MODE_REAL};
    logic [7:0] v [10] = '{8'h00, 8'h80, 8'h88, 8'h90, 8'h40, 8'h08,
      8'h00, 8'h88, 8'h00, 8'h40};
    logic [4:0] e [10] = '{5'd14, 5'd18, 5'd16, 5'd14, 5'd20, 5'd14,
      5'd18, 5'd18, 5'd16, 5'd20};
    for (int i = 0; i < 10; i++)
    begin
      wreg(ADDR_REMAP, v[i]);
      mode <= m[i];
      tick(3);
      check("res", 20'(res), 20'(e[i]));
    end
    wreg(ADDR_REMAP, 8'hff);
    rchk(ADDR_REMAP, 8'hf8);
    wreg(ADDR_REMAP, 8'h00);
    mode <= MODE_BYPASS;
    $display("t_res done");
  endtask

  task automatic t_frame_clock;
    for (int m = 0; m < 3; m++)
      for (int l = 0; l < 3; l++)
      begin
        @(posedge clk);
        mode <= sodrc_mode_t'(m);
        lanes <= sodrc_lanes_t'(l);
        tick(3);
        check("src", 20'(src), 20'(m == 2 && l != 2));
        check("div", 20'(div), 20'(m != 2 && l == 0));
        check("str", 20'(str), 20'(m == 2 && l == 2));
      end
    @(posedge clk);
    mode <= MODE_BYPASS;
    lanes <= LANES_ONE;
    $display("t_frame_clock done");
  endtask

  task automatic t_route;
    logic ap [9] = '{0, 1, 1, 1, 1, 1, 1, 1, 1};
    logic [7:0] v [9] = '{8'h0e, 8'h06, 8'h0e, 8'h16, 8'h3e, 8'h1e,
      8'h0a, 8'h0c, 8'h3a};
    logic [13:0] ea [9] = '{14'h200, 14'h200, 14'h200, 14'h100, 14'h180,
      14'h200, 14'h200, 14'h200, 14'h200};
    logic [13:0] eb [9] = '{14'h100, 14'h100, 14'h200, 14'h100, 14'h180,
      14'h200, 14'h100, 14'h200, 14'h100};
    for (int i = 0; i < 9; i++)
    begin
      wreg(ADDR_ROUTE, v[i]);
      apply <= ap[i];
      tick(3);
      check("filter", 20'(filt), 20'(v[i][1]));
      check("feature", 20'(feat), 20'(v[i][2]));
      push(14'h0200, 14'h0100);
      see({6'h0, ea[i]}, {6'h0, eb[i]});
    end
    wreg(ADDR_ROUTE, 8'hff);
    rchk(ADDR_ROUTE, 8'h3e);
    wreg(ADDR_ROUTE, 8'h00);
    $display("t_route done");
  endtask

  task automatic t_pat;
    wreg(ADDR_PAT_LO, 8'h00);
    wreg(ADDR_PAT_MID, 8'h00);
    wreg(ADDR_PAT_HI, 8'hff);
    rchk(ADDR_PAT_HI, 8'h0f);
    wreg(ADDR_REMAP, 8'h80);
    frames(3);
    push(14'h2001, 14'h0003);
    see(20'h20010, 20'h00030);
    check("bypass pattern", rx_fc, 20'h3fe00);
    wreg(ADDR_REMAP, 8'h00);
    wreg(ADDR_PAT_MID, 8'hfc);
    mode <= MODE_REAL;
    lanes <= LANES_TWO;
    frames(3);
    check("real pattern", rx_fc, 20'h3ff00);
    lanes <= LANES_ONE;
    wreg(ADDR_PAT_MID, 8'hf8);
    frames(3);
    check("real 1-wire pattern", rx_fc, 20'h3fe00);
    @(posedge clk);
    mode <= MODE_BYPASS;
    frames(3);
    $display("t_pat done");
  endtask

  task automatic t_fifo;
    int acc = 0;
    int low = 0;
    logic [7:0] nz0;
    nz0 = rx_nz;
    @(posedge clk);
    sv <= 1'b1;
    sa <= 14'h0011;
    sb <= 14'h0022;
    repeat (40)
    begin
      @(posedge clk);
      if (sr === 1'b1)
        acc++;
      else
        low++;
    end
    sv <= 1'b0;
    check("refused", 20'(low > 0), 20'h1);
    tick((acc + 3) * 14);
    check("drained", 20'(rx_nz - nz0), 20'(acc));
    $display("t_fifo done");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      wrap_up;
    end
  end

  initial
  begin
    tick(4);
    rst <= 1'b0;
    t_reset;
    t_drive;
    t_skew;
    t_res;
    t_frame_clock;
    t_route;
    t_pat;
    t_fifo;
    wrap_up;
  end
endmodule

`default_nettype wire
